// File: lane_cfg_pkg.sv
package lane_cfg_pkg;

  // ----------------------------------------------------------------
  // Register map
  // ----------------------------------------------------------------
  localparam int unsigned NUM_REGS = 5;
  localparam logic [7:0] ADDR_RESERVED_SPARE_A = 8'h30;
  localparam logic [7:0] ADDR_RESERVED_SPARE_B = 8'h31;
  localparam logic [7:0] ADDR_LANE_IDLE_DETECT_CFG = 8'h32;
  localparam logic [7:0] ADDR_LANE_INPUT_EQUALIZER = 8'h33;
  localparam logic [7:0] ADDR_LANE_OUTPUT_SWING_CFG = 8'h34;

  // Index of each register in the bank
  localparam int unsigned IDX_SPARE_A = 0;
  localparam int unsigned IDX_SPARE_B = 1;
  localparam int unsigned IDX_IDLE_DETECT = 2;
  localparam int unsigned IDX_EQUALIZER = 3;
  localparam int unsigned IDX_SWING = 4;

  // ----------------------------------------------------------------
  // Reset values
  // ----------------------------------------------------------------
  localparam logic [7:0] RST_RESERVED_SPARE_A = 8'h00;
  localparam logic [7:0] RST_RESERVED_SPARE_B = 8'h00;
  localparam logic [7:0] RST_LANE_IDLE_DETECT_CFG = 8'h00;
  localparam logic [7:0] RST_LANE_INPUT_EQUALIZER = 8'h2f;
  localparam logic [7:0] RST_LANE_OUTPUT_SWING_CFG = 8'had;
  localparam logic [7:0] RDATA_UNMAPPED = 8'h00;

  // ----------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------
  localparam int unsigned IDLE_MANUAL_PERMIT_BIT = 5;
  localparam int unsigned OUTPUT_MUTE_SEL_BIT = 4;
  localparam int unsigned DET_MODE_HI = 3;
  localparam int unsigned DET_MODE_LO = 2;
  localparam int unsigned EQ_LEVEL_HI = 7;
  localparam int unsigned EQ_LEVEL_LO = 0;
  localparam int unsigned SHORT_PROTECT_BIT = 7;
  localparam int unsigned RATE_GROUP_BIT = 6;
  localparam int unsigned OUTPUT_SWING_HI = 2;
  localparam int unsigned OUTPUT_SWING_LO = 0;

  // ----------------------------------------------------------------
  // Far-end detect mode codes
  // ----------------------------------------------------------------
  localparam logic [1:0] DET_MODE_HIZ = 2'h0;
  localparam logic [1:0] DET_MODE_AUTO_LIMITED = 2'h1;
  localparam logic [1:0] DET_MODE_AUTO_FOREVER = 2'h2;
  localparam logic [1:0] DET_MODE_FIXED_50 = 2'h3;

  // ----------------------------------------------------------------
  // Detection timing
  // ----------------------------------------------------------------
  localparam int unsigned CLK_FREQ_HZ = 100_000_000;
  localparam int unsigned DETECT_PERIOD_MS = 12;
  localparam int unsigned DETECT_WINDOW_MS = 600;
  localparam int unsigned DETECT_PERIOD_CYC_DFLT = (CLK_FREQ_HZ / 1000) * DETECT_PERIOD_MS;
  localparam int unsigned DETECT_MAX_ATTEMPTS = DETECT_WINDOW_MS / DETECT_PERIOD_MS;
  localparam logic [31:0] TIMER_ZERO = 32'h0000_0000;
  localparam logic [5:0] ATTEMPTS_ZERO = 6'h00;
  localparam logic [5:0] ATTEMPT_STEP = 6'h01;
  localparam logic [31:0] TIMER_STEP = 32'h0000_0001;

  typedef enum logic [2:0] {
    ST_HIZ,
    ST_FIXED,
    ST_SEARCH,
    ST_FOUND,
    ST_STOPPED
  } det_state_t;

endpackage

// File: lane_detect_if.sv
interface lane_detect_if;
  logic [1:0] mode;
  logic far_end_present;
  logic attempt;
  logic term_50;
  logic found;

  modport ctrl (
    output mode,
    output far_end_present,
    input attempt,
    input term_50,
    input found
  );

  modport engine (
    input mode,
    input far_end_present,
    output attempt,
    output term_50,
    output found
  );
endinterface

// File: lane_far_end_detect.sv
module lane_far_end_detect
  import lane_cfg_pkg::*;
#(
  parameter int unsigned DETECT_PERIOD_CYC = DETECT_PERIOD_CYC_DFLT
)(
  input wire logic clk_sys_i,
  input wire logic rstn_i,
  lane_detect_if.engine det
);

  localparam logic [31:0] PERIOD_LAST = 32'(DETECT_PERIOD_CYC - 1);
  localparam logic [5:0] ATTEMPTS_LAST = 6'(DETECT_MAX_ATTEMPTS - 1);

  det_state_t state_r, state_nxt;
  logic [1:0] mode_r, mode_nxt;
  logic [31:0] timer_r, timer_nxt;
  logic [5:0] attempts_r, attempts_nxt;
  logic attempt_r, attempt_nxt;
  logic term_50_r, term_50_nxt;
  logic found_r, found_nxt;

  // ----------------------------------------------------------------
  // Mode entry state
  // ----------------------------------------------------------------
  function automatic det_state_t entry_state(input logic [1:0] mode);
    det_state_t st;
    st = ST_SEARCH;
    if (mode == DET_MODE_HIZ)
    begin
      st = ST_HIZ;
    end
    else if (mode == DET_MODE_FIXED_50)
    begin
      st = ST_FIXED;
    end
    return st;
  endfunction

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  always_comb
  begin
    state_nxt = state_r;
    mode_nxt = det.mode;
    timer_nxt = timer_r;
    attempts_nxt = attempts_r;
    attempt_nxt = 1'b0;
    if (det.mode != mode_r)
    begin
      state_nxt = entry_state(det.mode);
      timer_nxt = TIMER_ZERO;
      attempts_nxt = ATTEMPTS_ZERO;
    end
    else
    begin
      unique case (state_r)
        ST_HIZ, ST_FIXED, ST_FOUND, ST_STOPPED:
        begin
          timer_nxt = TIMER_ZERO;
        end
        ST_SEARCH:
        begin
          if (timer_r == PERIOD_LAST)
          begin
            timer_nxt = TIMER_ZERO;
            attempt_nxt = 1'b1;
            attempts_nxt = attempts_r + ATTEMPT_STEP;
            if (det.far_end_present)
            begin
              state_nxt = ST_FOUND;
            end
            else if ((det.mode == DET_MODE_AUTO_LIMITED) && (attempts_r == ATTEMPTS_LAST))
            begin
              state_nxt = ST_STOPPED;
            end
            else if (det.mode == DET_MODE_AUTO_FOREVER)
            begin
              attempts_nxt = ATTEMPTS_ZERO;
            end
          end
          else
          begin
            timer_nxt = timer_r + TIMER_STEP;
          end
        end
      endcase
    end
    term_50_nxt = (state_nxt == ST_FIXED) || (state_nxt == ST_FOUND);
    found_nxt = (state_nxt == ST_FOUND);
  end

  always_ff @(posedge clk_sys_i or negedge rstn_i)
  begin
    if (!rstn_i)
    begin
      state_r <= ST_HIZ;
      mode_r <= DET_MODE_HIZ;
      timer_r <= TIMER_ZERO;
      attempts_r <= ATTEMPTS_ZERO;
      attempt_r <= 1'b0;
      term_50_r <= 1'b0;
      found_r <= 1'b0;
    end
    else
    begin
      state_r <= state_nxt;
      mode_r <= mode_nxt;
      timer_r <= timer_nxt;
      attempts_r <= attempts_nxt;
      attempt_r <= attempt_nxt;
      term_50_r <= term_50_nxt;
      found_r <= found_nxt;
    end
  end

  assign det.attempt = attempt_r;
  assign det.term_50 = term_50_r;
  assign det.found = found_r;

endmodule // lane_far_end_detect

// File: lane_config_register_bank.sv
module lane_config_register_bank
  import lane_cfg_pkg::*;
#(
  parameter int unsigned DETECT_PERIOD_CYC = DETECT_PERIOD_CYC_DFLT
)(
  input wire logic clk_sys_i,
  input wire logic rstn_i,
  input wire logic wr_en_i,
  input wire logic rd_en_i,
  input wire logic [7:0] addr_i,
  input wire logic [7:0] wdata_i,
  input wire logic [1:0] det_mode_pin_i,
  input wire logic idle_detected_i,
  input wire logic far_end_present_i,
  output logic [7:0] rdata_o,
  output logic rdata_valid_o,
  output logic lane_mute_o,
  output logic term_50_o,
  output logic detect_attempt_o,
  output logic far_end_found_o,
  output logic [7:0] eq_level_o,
  output logic short_protect_en_o,
  output logic rate_gen12_o,
  output logic [2:0] output_swing_o
);

  // ----------------------------------------------------------------
  // Register table
  // ----------------------------------------------------------------
  localparam logic [7:0] REG_ADDR [NUM_REGS] = '{
    ADDR_RESERVED_SPARE_A,
    ADDR_RESERVED_SPARE_B,
    ADDR_LANE_IDLE_DETECT_CFG,
    ADDR_LANE_INPUT_EQUALIZER,
    ADDR_LANE_OUTPUT_SWING_CFG
  };

  localparam logic [7:0] REG_RST [NUM_REGS] = '{
    RST_RESERVED_SPARE_A,
    RST_RESERVED_SPARE_B,
    RST_LANE_IDLE_DETECT_CFG,
    RST_LANE_INPUT_EQUALIZER,
    RST_LANE_OUTPUT_SWING_CFG
  };

  // ----------------------------------------------------------------
  // Address decode
  // ----------------------------------------------------------------
  function automatic logic [NUM_REGS-1:0] reg_hit(input logic [7:0] addr);
    logic [NUM_REGS-1:0] hit;
    hit = '0;
    for (int i = 0; i < NUM_REGS; i++)
    begin
      hit[i] = (addr == REG_ADDR[i]);
    end
    return hit;
  endfunction

  logic [NUM_REGS-1:0] wr_hit;
  logic [NUM_REGS-1:0] rd_hit;

  assign wr_hit = wr_en_i ? reg_hit(addr_i) : '0;
  assign rd_hit = rd_en_i ? reg_hit(addr_i) : '0;

  // ----------------------------------------------------------------
  // Register storage
  // ----------------------------------------------------------------
  logic [7:0] regs_r [NUM_REGS];
  logic [7:0] regs_nxt [NUM_REGS];

  genvar g;
  generate
    for (g = 0; g < NUM_REGS; g++)
    begin : g_reg
      always_comb
      begin
        regs_nxt[g] = regs_r[g];
        if (wr_hit[g])
        begin
          regs_nxt[g] = wdata_i;
        end
      end

      always_ff @(posedge clk_sys_i or negedge rstn_i)
      begin
        if (!rstn_i)
        begin
          regs_r[g] <= REG_RST[g];
        end
        else
        begin
          regs_r[g] <= regs_nxt[g];
        end
      end
    end
  endgenerate

  // ----------------------------------------------------------------
  // Read path
  // ----------------------------------------------------------------
  logic [7:0] rdata_r, rdata_nxt;
  logic rdata_valid_r, rdata_valid_nxt;

  always_comb
  begin
    rdata_nxt = rdata_r;
    rdata_valid_nxt = rd_en_i;
    if (rd_en_i)
    begin
      rdata_nxt = RDATA_UNMAPPED;
      for (int i = 0; i < NUM_REGS; i++)
      begin
        if (rd_hit[i])
        begin
          rdata_nxt = regs_r[i];
        end
      end
    end
  end

  always_ff @(posedge clk_sys_i or negedge rstn_i)
  begin
    if (!rstn_i)
    begin
      rdata_r <= RDATA_UNMAPPED;
      rdata_valid_r <= 1'b0;
    end
    else
    begin
      rdata_r <= rdata_nxt;
      rdata_valid_r <= rdata_valid_nxt;
    end
  end

  // ----------------------------------------------------------------
  // Detect mode selection
  // ----------------------------------------------------------------
  logic det_mode_written_r, det_mode_written_nxt;
  logic [1:0] det_mode_r, det_mode_nxt;
  logic far_end_present_r, far_end_present_nxt;

  always_comb
  begin
    det_mode_written_nxt = det_mode_written_r | wr_hit[IDX_IDLE_DETECT];
    if (det_mode_written_r)
    begin
      det_mode_nxt = regs_r[IDX_IDLE_DETECT][DET_MODE_HI:DET_MODE_LO];
    end
    else
    begin
      det_mode_nxt = det_mode_pin_i;
    end
    far_end_present_nxt = far_end_present_i;
  end

  always_ff @(posedge clk_sys_i or negedge rstn_i)
  begin
    if (!rstn_i)
    begin
      det_mode_written_r <= 1'b0;
      det_mode_r <= DET_MODE_HIZ;
      far_end_present_r <= 1'b0;
    end
    else
    begin
      det_mode_written_r <= det_mode_written_nxt;
      det_mode_r <= det_mode_nxt;
      far_end_present_r <= far_end_present_nxt;
    end
  end

  // ----------------------------------------------------------------
  // Far-end detection engine
  // ----------------------------------------------------------------
  lane_detect_if det_if ();

  assign det_if.mode = det_mode_r;
  assign det_if.far_end_present = far_end_present_r;

  lane_far_end_detect #(
    .DETECT_PERIOD_CYC(DETECT_PERIOD_CYC)
  ) u_detect (
    .clk_sys_i(clk_sys_i),
    .rstn_i(rstn_i),
    .det(det_if.engine)
  );

  // ----------------------------------------------------------------
  // Idle control
  // ----------------------------------------------------------------
  logic lane_mute_r, lane_mute_nxt;

  always_comb
  begin
    if (regs_r[IDX_IDLE_DETECT][IDLE_MANUAL_PERMIT_BIT])
    begin
      lane_mute_nxt = regs_r[IDX_IDLE_DETECT][OUTPUT_MUTE_SEL_BIT];
    end
    else
    begin
      lane_mute_nxt = idle_detected_i;
    end
  end

  always_ff @(posedge clk_sys_i or negedge rstn_i)
  begin
    if (!rstn_i)
    begin
      lane_mute_r <= 1'b0;
    end
    else
    begin
      lane_mute_r <= lane_mute_nxt;
    end
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  assign rdata_o = rdata_r;
  assign rdata_valid_o = rdata_valid_r;
  assign lane_mute_o = lane_mute_r;
  assign term_50_o = det_if.term_50;
  assign detect_attempt_o = det_if.attempt;
  assign far_end_found_o = det_if.found;
  assign eq_level_o = regs_r[IDX_EQUALIZER][EQ_LEVEL_HI:EQ_LEVEL_LO];
  assign short_protect_en_o = regs_r[IDX_SWING][SHORT_PROTECT_BIT];
  assign rate_gen12_o = regs_r[IDX_SWING][RATE_GROUP_BIT];
  assign output_swing_o = regs_r[IDX_SWING][OUTPUT_SWING_HI:OUTPUT_SWING_LO];

endmodule // lane_config_register_bank

// File: lane_cfg_checker.sv
module lane_cfg_checker
  import lane_cfg_pkg::*;
#(
  parameter int unsigned DETECT_PERIOD_CYC = DETECT_PERIOD_CYC_DFLT
)(
  input wire logic clk_sys_i,
  input wire logic rstn_i,
  input wire logic wr_en_i,
  input wire logic rd_en_i,
  input wire logic [7:0] addr_i,
  input wire logic [7:0] wdata_i,
  input wire logic [1:0] det_mode_pin_i,
  input wire logic idle_detected_i,
  input wire logic far_end_present_i,
  input wire logic [7:0] rdata_o,
  input wire logic rdata_valid_o,
  input wire logic lane_mute_o,
  input wire logic term_50_o,
  input wire logic detect_attempt_o,
  input wire logic far_end_found_o,
  input wire logic [7:0] eq_level_o,
  input wire logic short_protect_en_o,
  input wire logic rate_gen12_o,
  input wire logic [2:0] output_swing_o
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge clk_sys_i); endclocking
  default disable iff (!rstn_i);
  wire logic wr_idle = wr_en_i && addr_i == ADDR_LANE_IDLE_DETECT_CFG;
  // ----------------------------------------
  // Sequences
  // ----------------------------------------
  sequence manual_wr_s;
    wr_idle && wdata_i[5] ##1 !wr_idle;
  endsequence
  sequence auto_wr_s;
    wr_idle && !wdata_i[5] ##1 !wr_idle ##1 1'b1;
  endsequence
  sequence fixed_mode_s;
    wr_idle && wdata_i[3] == wdata_i[2] ##1 !wr_idle [*4];
  endsequence
  // ----------------------------------------
  // Assertions
  // ----------------------------------------
  a_eq_update:
    assert property (wr_en_i && addr_i == ADDR_LANE_INPUT_EQUALIZER |=>
      eq_level_o == $past(wdata_i)) else $error("eq level not updated");
  a_swing_fields:
    assert property (wr_en_i && addr_i == ADDR_LANE_OUTPUT_SWING_CFG |=>
      {short_protect_en_o, rate_gen12_o, output_swing_o} ==
      {$past(wdata_i[7]), $past(wdata_i[6]), $past(wdata_i[2:0])})
      else $error("swing fields wrong");
  a_read_valid:
    assert property (rdata_valid_o == $past(rd_en_i)) else $error("read valid wrong");
  a_unmapped_read:
    assert property (rd_en_i && (addr_i < ADDR_RESERVED_SPARE_A ||
      addr_i > ADDR_LANE_OUTPUT_SWING_CFG) |=> rdata_o == RDATA_UNMAPPED)
      else $error("unmapped read not zero");
  a_mute_manual:
    assert property (manual_wr_s |=> lane_mute_o == $past(wdata_i[4], 2))
      else $error("manual mute wrong");
  a_mute_auto:
    assert property (auto_wr_s |-> lane_mute_o == $past(idle_detected_i))
      else $error("auto mute wrong");
  a_fixed_mode:
    assert property (fixed_mode_s |-> term_50_o == $past(wdata_i[3], 4))
      else $error("fixed termination wrong");
  a_attempt_gap:
    assert property (detect_attempt_o |=> !detect_attempt_o [*8])
      else $error("attempts too close");
  a_found_term:
    assert property ($rose(far_end_found_o) |-> term_50_o && detect_attempt_o)
      else $error("found without termination");
endmodule // lane_cfg_checker

bind lane_config_register_bank lane_cfg_checker #(
  .DETECT_PERIOD_CYC(DETECT_PERIOD_CYC)
) i_chk (.*);

// File: far_end_receiver_model.sv
module far_end_receiver_model (
  input wire logic clk_sys_i,
  input wire logic rstn_i,
  input wire logic arm_i,
  input wire logic [7:0] need_i,
  input wire logic attempt_i,
  output logic present_o
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0] seen_r;
  // Receiver appears after a set number of detect attempts
  always_ff @(posedge clk_sys_i or negedge rstn_i)
    if (!rstn_i)
      seen_r <= 8'h00;
    else if (!arm_i)
      seen_r <= 8'h00;
    else if (attempt_i)
      seen_r <= seen_r + 8'h01;
  assign present_o = arm_i && seen_r >= need_i;
endmodule // far_end_receiver_model

// File: test_lane_config_register_bank.sv
module test_lane_config_register_bank
  import lane_cfg_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int unsigned P = 20;
  localparam logic [7:0] IC = ADDR_LANE_IDLE_DETECT_CFG;
  typedef struct packed {logic [7:0] a; logic [7:0] d; logic [7:0] rd; logic [7:0] eq;
    logic [4:0] sw;} row_t;
  logic clk_sys_i, rstn_i, wr_en_i, rd_en_i, idle_detected_i, far_end_present_i, arm;
  logic [7:0] addr_i, wdata_i, rdata_o, eq_level_o, need, got;
  logic [1:0] det_mode_pin_i;
  logic rdata_valid_o, lane_mute_o, term_50_o, detect_attempt_o, far_end_found_o;
  logic short_protect_en_o, rate_gen12_o;
  logic [2:0] output_swing_o;
  int mismatches, checks, cycles, n, gap;
  logic [7:0] rst_exp [5] = '{8'h00, 8'h00, 8'h00, 8'h2f, 8'had};
  row_t rows [7] = '{'{8'h30, 8'h00, 8'h00, 8'h2f, 5'h15}, '{8'h31, 8'h00, 8'h00, 8'h2f, 5'h15},
    '{8'h33, 8'h00, 8'h00, 8'h00, 5'h15}, '{8'h33, 8'hff, 8'hff, 8'hff, 5'h15},
    '{8'h34, 8'h6a, 8'h6a, 8'hff, 5'h0a}, '{8'h35, 8'h55, 8'h00, 8'hff, 5'h0a},
    '{8'h2f, 8'h77, 8'h00, 8'hff, 5'h0a}};

  lane_config_register_bank #(.DETECT_PERIOD_CYC(P)) i_dut (.*);
  far_end_receiver_model i_far (.clk_sys_i(clk_sys_i), .rstn_i(rstn_i), .arm_i(arm),
    .need_i(need), .attempt_i(detect_attempt_o), .present_o(far_end_present_i));

  // ----------------------------------------
  // Clock, timeout and tasks
  // ----------------------------------------
  initial
  begin
    clk_sys_i = 1'b0;
    forever #5 clk_sys_i = ~clk_sys_i;
  end
  always @(posedge clk_sys_i)
  begin
    cycles++;
    if (cycles == 10000)
    begin
      mismatches++;
      results();
    end
  end
  task automatic results();
    $display("checks %0d mismatches %0d", checks, mismatches);
    if (mismatches == 0 && checks > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask
  task automatic chk(input string name, input logic [23:0] exp, input logic [23:0] seen);
    checks++;
    if (seen !== exp)
    begin
      mismatches++;
      $display("wrong value %s expected %h seen %h", name, exp, seen);
    end
  endtask
  task automatic wait_n(input int k);
    repeat (k) @(negedge clk_sys_i);
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    wr_en_i = 1'b1;
    addr_i = a;
    wdata_i = d;
    wait_n(1);
    wr_en_i = 1'b0;
    wait_n(1);
  endtask
  task automatic rd(input logic [7:0] a);
    rd_en_i = 1'b1;
    addr_i = a;
    wait_n(1);
    rd_en_i = 1'b0;
    chk("rdata_valid", 24'h1, {23'h0, rdata_valid_o});
    got = rdata_o;
    wait_n(1);
  endtask
  // Count attempts and their spacing until found or the cycle limit
  task automatic hunt(input int lim);
    n = 0;
    gap = 0;
    repeat (lim)
    begin
      wait_n(1);
      gap++;
      if (detect_attempt_o === 1'b1)
      begin
        if (n > 0)
          chk("attempt gap", 24'(P), 24'(gap));
        n++;
        gap = 0;
        if (far_end_found_o === 1'b1)
          break;
      end
    end
  endtask

  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial
  begin
    {rstn_i, wr_en_i, rd_en_i, arm, idle_detected_i} = 5'h01;
    {addr_i, wdata_i, need, det_mode_pin_i} = 26'h0;
    wait_n(16);
    chk("reset outputs", {8'h2f, 5'h15, 5'h0}, {eq_level_o, short_protect_en_o, rate_gen12_o,
      output_swing_o, lane_mute_o, term_50_o, detect_attempt_o, far_end_found_o,
      rdata_valid_o});
    rstn_i = 1'b1;
    for (int i = 0; i < 5; i++)
    begin
      rd(8'h30 + 8'(i));
      chk("reset value", rst_exp[i], got);
    end
    $display("test reset done");
    foreach (rows[i])
    begin
      wr(rows[i].a, rows[i].d);
      rd(rows[i].a);
      chk("readback", rows[i].rd, got);
      chk("fields", {rows[i].eq, rows[i].sw}, {eq_level_o, short_protect_en_o,
        rate_gen12_o, output_swing_o});
    end
    for (int c = 0; c < 8; c++)
    begin
      wr(ADDR_LANE_OUTPUT_SWING_CFG, 8'ha8 | 8'(c));
      chk("swing code", 24'(c), {21'h0, output_swing_o});
    end
    $display("test registers done");
    det_mode_pin_i = 2'h3;
    wait_n(6);
    chk("pin fixed", 24'h1, {23'h0, term_50_o});
    wr(IC, 8'h00);
    wait_n(6);
    chk("reg hiz", 24'h0, {23'h0, term_50_o});
    wr(IC, 8'h0c);
    det_mode_pin_i = 2'h0;
    wait_n(6);
    chk("reg fixed", 24'h1, {23'h0, term_50_o});
    wr(IC, 8'h04);
    hunt(55 * P);
    chk("limited attempts", 24'd50, 24'(n));
    chk("limited term", 24'h0, {23'h0, term_50_o});
    need = 8'd60;
    arm = 1'b1;
    wr(IC, 8'h08);
    hunt(70 * P);
    chk("forever attempts", 24'd61, 24'(n));
    chk("forever found", 24'h3, {22'h0, far_end_found_o, term_50_o});
    arm = 1'b0;
    need = 8'd3;
    wr(IC, 8'h04);
    arm = 1'b1;
    hunt(10 * P);
    chk("limited found", 24'h004_003, {n[11:0], 10'h0, far_end_found_o, term_50_o});
    $display("test detect done");
    idle_detected_i = 1'b0;
    wr(IC, 8'h30);
    wait_n(2);
    chk("manual mute", 24'h1, {23'h0, lane_mute_o});
    idle_detected_i = 1'b1;
    wr(IC, 8'h20);
    wait_n(2);
    chk("manual on", 24'h0, {23'h0, lane_mute_o});
    wr(IC, 8'h00);
    wait_n(2);
    chk("auto idle", 24'h1, {23'h0, lane_mute_o});
    idle_detected_i = 1'b0;
    wait_n(2);
    chk("auto active", 24'h0, {23'h0, lane_mute_o});
    $display("test idle done");
    det_mode_pin_i = 2'h3;
    rstn_i = 1'b0;
    wait_n(2);
    chk("midrun reset", {8'h2f, 5'h15, 5'h0}, {eq_level_o, short_protect_en_o, rate_gen12_o,
      output_swing_o, lane_mute_o, term_50_o, detect_attempt_o, far_end_found_o,
      rdata_valid_o});
    rstn_i = 1'b1;
    wait_n(6);
    chk("pin after reset", 24'h1, {23'h0, term_50_o});
    $display("test midrun reset done");
    results();
  end
endmodule // test_lane_config_register_bank
